/* core/hcrtc_core.sv */
// Hibernate calendar RTC core: counter, calendar, match, retention words
//
// How it works
// - One mode at a time: 24h, 12h, seconds.
// - Match field 0xff always matches in either calendar mode.
// - Wildcards give daily, hourly, minute, second repeats.
// - Sixteen 32-bit retention words kept.
// - Power-down option stops the crystal oscillator.
// - High drive for 24 pF, low 12 pF.
// - Option selects internal low-frequency oscillator.
// - Option forwards the clock to system.
// - One second per 32768 reference cycles.
// - Disabled block counts and matches nothing; drive pins and clock output off.
// - Read across midnight flagged invalid; retry later.
// - Match raises match-zero flag, maskable interrupt.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module hcrtc_core (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire hcrtc_pkg::hcrtc_bus_t bus,
    output logic [31:0]            rdata,
    input  wire logic              osc_input_pin,
    input  wire logic              internal_low_freq_osc,
    output logic                   irq,
    output logic                   osc_power_down_option,
    output logic                   crystal_high_drive,
    output logic                   crystal_low_drive,
    output logic                   sys_clk_out
);
    import hcrtc_pkg::*;

    // ********************************
    // State and helpers
    // ********************************
    typedef struct packed {
        logic [15:0][31:0] mem;     // Retention words
        hcrtc_ctl_t        ctl;     // Control settings
        logic [31:0]       cnt;     // Seconds counter
        hcrtc_cal_t        cal;     // Calendar, hour held 0..23
        logic [31:0]       match;   // Match 0, raw or calendar form
        logic [1:0]        stat;    // Sticky events
        logic [1:0]        mask;    // Interrupt enables
        logic [31:0]       rdata;   // Read answer
        logic              irq;     // Interrupt level
        logic              osc_pd;  // Oscillator power-down pin
        logic              hi_drv;  // High drive pin
        logic              lo_drv;  // Low drive pin
        logic              clk_out; // Forwarded clock
    } hcrtc_state_t;

    hcrtc_state_t st;         // Registered state
    hcrtc_state_t nx;         // Next state
    logic         sec_tick;   // One pulse per second
    logic         ref_level;  // Synchronised reference level
    logic         is12;       // 12-hour presentation active
    logic         is_cal;     // Either calendar mode active
    hcrtc_cal_t   cal_inc;    // Calendar one second on
    logic [31:0]  cal_cmp;    // Advanced time in register form
    logic [3:0]   fld_hit;    // Per-field match result
    logic         last_sec;   // 23:59:59, day about to roll
    logic [1:0]   ev;         // Events raised this cycle
    logic         mem_hit;    // Address lies in retention page
    hcrtc_mode_t  wr_mode;    // Mode requested by a control write

    // ********************************
    // Hour conversion
    // ********************************

    // Internal hour to register form; 12h form carries a PM flag
    function automatic logic [7:0] hr_out(input logic [7:0] h,
                                          input logic       h12);
        logic [7:0] r;
        r = h;
        if (h12) begin
            if (h == 8'h00) begin
                r = HR_NOON;
            end else if (h > HR_NOON) begin
                r = h - HR_NOON;
            end
            if (h >= HR_NOON) begin
                r = r | HR_PM;
            end
        end
        return r;
    endfunction : hr_out

    // Register form back to internal 0..23 hour
    function automatic logic [7:0] hr_in(input logic [7:0] h,
                                         input logic       h12);
        logic [7:0] r;
        r = h;
        if (h12) begin
            r = h & HR_MASK;
            if (r == HR_NOON) begin
                r = 8'h00;
            end
            if ((h & HR_PM) != 8'h00) begin
                r = r + HR_NOON;
            end
        end
        return r;
    endfunction : hr_in

    // Calendar advance by one second; days run 1..31 and wrap
    function automatic hcrtc_cal_t cal_step(input hcrtc_cal_t c);
        hcrtc_cal_t r;
        r = c;
        if (c.sec < MS_LAST) begin
            r.sec = c.sec + 8'h1;
        end else begin
            r.sec = 8'h00;
            if (c.min < MS_LAST) begin
                r.min = c.min + 8'h1;
            end else begin
                r.min = 8'h00;
                if (c.hour < HOUR_LAST) begin
                    r.hour = c.hour + 8'h1;
                end else begin
                    r.hour = 8'h00;
                    r.day  = (c.day < DAY_LAST) ? c.day + 8'h1
                                                : DAY_FIRST;
                end
            end
        end
        return r;
    endfunction : cal_step

    // ********************************
    // Reference divider
    // ********************************

    // Source select and 32768 divide live in the leaf
    hcrtc_ref_div u_div (
        .clk_sys                  (clk_sys),
        .rst_n                    (rst_n),
        .osc_input_pin            (osc_input_pin),
        .internal_low_freq_osc    (internal_low_freq_osc),
        .select_low_freq_internal (st.ctl.select_low_freq_internal),
        .run                      (st.ctl.en),
        .ref_level                (ref_level),
        .sec_tick                 (sec_tick)
    );

    // ********************************
    // Match compare
    // ********************************

    assign is12     = (st.ctl.mode == calendar_12h_mode);
    assign is_cal   = (st.ctl.mode != rtc_seconds_mode);
    assign cal_inc  = cal_step(st.cal);
    // Compare in register form so 12h match values line up
    assign cal_cmp  = {cal_inc.day, hr_out(cal_inc.hour, is12),
                       cal_inc.min, cal_inc.sec};
    assign last_sec = (st.cal.hour == HOUR_LAST) &&
                      (st.cal.min == MS_LAST) &&
                      (st.cal.sec == MS_LAST);
    assign mem_hit  = (bus.addr[7:6] == MEM_PAGE);

    // Wildcard bytes drop out, giving repeat rates
    for (genvar i = 0; i < 4; i++) begin : g_fld
        assign fld_hit[i] = (st.match[8*i +: 8] == WILDCARD) ||
                            (st.match[8*i +: 8] == cal_cmp[8*i +: 8]);
    end

    // ********************************
    // Next state
    // ********************************

    // Tick first, then reads, then writes, so a write wins
    always_comb begin
        nx       = st;
        ev       = '0;
        nx.rdata = '0;
        wr_mode  = rtc_seconds_mode;

        // Timekeeping only while enabled
        if (st.ctl.en && sec_tick) begin
            if (!is_cal) begin
                nx.cnt       = st.cnt + 32'h1;
                ev[ST_MATCH] = (st.cnt + 32'h1 == st.match);
            end else begin
                nx.cal       = cal_inc;
                ev[ST_MATCH] = &fld_hit;
            end
        end

        // Read decode; unmapped addresses answer zero
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CTL: begin
                    nx.rdata = {25'h0, st.ctl};
                end
                ADDR_CNT: begin
                    nx.rdata = st.cnt;
                end
                ADDR_CAL: begin
                    nx.rdata = {st.cal.day, hr_out(st.cal.hour, is12),
                                st.cal.min, st.cal.sec};
                    // Value may tear across midnight
                    ev[ST_RD_INV] = last_sec;
                end
                ADDR_MATCH: begin
                    nx.rdata = st.match;
                end
                ADDR_STAT: begin
                    nx.rdata = {30'h0, st.stat};
                    nx.stat  = '0;
                end
                ADDR_MASK: begin
                    nx.rdata = {30'h0, st.mask};
                end
                default: begin
                    if (mem_hit) begin
                        nx.rdata = st.mem[bus.addr[5:2]];
                    end
                end
            endcase
        end

        // Write decode; unmapped writes are dropped
        if (bus.wr) begin
            case (bus.addr)
                ADDR_CTL: begin
                    // Reserved code falls back to the seconds counter
                    case (bus.wdata[CTL_MODE +: 2])
                        2'b01:   wr_mode = calendar_24h_mode;
                        2'b10:   wr_mode = calendar_12h_mode;
                        default: wr_mode = rtc_seconds_mode;
                    endcase
                    nx.ctl.mode = wr_mode;
                    nx.ctl.en   = bus.wdata[CTL_EN];
                    nx.ctl.osc_power_down_option =
                        bus.wdata[CTL_OSC_PD];
                    nx.ctl.crystal_high_drive = bus.wdata[CTL_HI_DRV];
                    nx.ctl.select_low_freq_internal =
                        bus.wdata[CTL_LFI];
                    nx.ctl.clock_out_to_system = bus.wdata[CTL_CLKOUT];
                end
                ADDR_CNT: begin
                    nx.cnt = bus.wdata;
                end
                ADDR_CAL: begin
                    // Software may only trust this in a calendar mode
                    nx.cal = {bus.wdata[31:24],
                              hr_in(bus.wdata[23:16], is12),
                              bus.wdata[15:8], bus.wdata[7:0]};
                end
                ADDR_MATCH: begin
                    // Only match zero exists
                    nx.match = bus.wdata;
                end
                ADDR_MASK: begin
                    nx.mask = bus.wdata[1:0];
                end
                default: begin
                    if (mem_hit) begin
                        nx.mem[bus.addr[5:2]] = bus.wdata;
                    end
                end
            endcase
        end

        // New events beat a read clear in the same cycle
        nx.stat = nx.stat | ev;
        nx.irq  = |(st.stat & st.mask);

        // Pin controls; a disabled block parks the oscillator
        nx.osc_pd = !st.ctl.en || st.ctl.osc_power_down_option;
        nx.hi_drv = !nx.osc_pd && st.ctl.crystal_high_drive;
        nx.lo_drv = !nx.osc_pd && !st.ctl.crystal_high_drive;
        // Forwarding follows whichever source is selected
        nx.clk_out = st.ctl.en && st.ctl.clock_out_to_system &&
                     ref_level;
    end

    // ********************************
    // State register
    // ********************************

    // Retention words clear only on the battery-side reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st        <= '0;
            st.ctl    <= CTL_RST;
            st.cal    <= CAL_RST;
            st.osc_pd <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from the register
    assign rdata                 = st.rdata;
    assign irq                   = st.irq;
    assign osc_power_down_option = st.osc_pd;
    assign crystal_high_drive    = st.hi_drv;
    assign crystal_low_drive     = st.lo_drv;
    assign sys_clk_out           = st.clk_out;

    // ********************************
    // Checks
    // ********************************
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_mode_legal: assert property (
        st.ctl.mode != 2'b11)
        else $error("illegal counter mode held");

    chk_wild_all: assert property (
        st.ctl.en && sec_tick && is_cal
        && (st.match == 32'hffffffff
            || (st.match == {WILDCARD, 24'h0} && !is12 && last_sec))
        |=> st.stat[ST_MATCH])
        else $error("wildcard match missed a tick");

    chk_sec_field: assert property (
        $rose(st.stat[ST_MATCH]) && is_cal && !$past(bus.wr)
        && st.match[7:0] != WILDCARD |-> st.cal.sec == st.match[7:0])
        else $error("match flagged with wrong second");

    chk_cnt_match: assert property (
        $rose(st.stat[ST_MATCH]) && !is_cal && !$past(bus.wr)
        |-> st.cnt == st.match)
        else $error("counter match flagged off value");

    chk_mem_store: assert property (
        bus.wr && mem_hit
        |=> st.mem[$past(bus.addr[5:2])] == $past(bus.wdata))
        else $error("retention word not stored");

    chk_osc_off: assert property (
        st.ctl.osc_power_down_option |=> osc_power_down_option
        && !crystal_high_drive && !crystal_low_drive)
        else $error("oscillator still driven when powered down");

    chk_drive_one: assert property (
        !(crystal_high_drive && crystal_low_drive))
        else $error("both crystal drive levels active");

    chk_idle_off: assert property (
        !st.ctl.en && !bus.wr
        |=> $stable(st.cnt) && $stable(st.cal) && !sys_clk_out)
        else $error("disabled block still active");

    chk_midnight_rd: assert property (
        bus.rd && bus.addr == ADDR_CAL && last_sec
        |=> st.stat[ST_RD_INV] ##1 (irq || !$past(st.mask[ST_RD_INV])))
        else $error("midnight read not flagged");

    chk_stat_read: assert property (
        bus.rd && bus.addr == ADDR_STAT
        |=> rdata == {30'h0, $past(st.stat)})
        else $error("status read answer wrong");

endmodule : hcrtc_core

/* core/hcrtc_ref_div.sv */
// Reference clock synchroniser and one-second divider
`timescale 1ns/100ps
module hcrtc_ref_div (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic osc_input_pin,
    input  wire logic internal_low_freq_osc,
    input  wire logic select_low_freq_internal,
    input  wire logic run,
    output logic      ref_level,
    output logic      sec_tick
);
    import hcrtc_pkg::*;

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [1:0]  osc_s;  // Crystal pin synchroniser
        logic [1:0]  lfi_s;  // Internal oscillator synchroniser
        logic        lvl;    // Selected level, also edge history
        logic [14:0] cnt;    // Reference edges this second
        logic        tick;   // One-cycle second pulse
    } hcrtc_div_t;

    hcrtc_div_t st;          // Registered state
    hcrtc_div_t nx;          // Next state
    logic       sel_now;     // Selected synchronised level

    // Next state: only second flops feed the source select
    always_comb begin
        nx       = st;
        nx.osc_s = {st.osc_s[0], osc_input_pin};
        nx.lfi_s = {st.lfi_s[0], internal_low_freq_osc};
        sel_now  = select_low_freq_internal ? st.lfi_s[1]
                                            : st.osc_s[1];
        nx.lvl   = sel_now;
        nx.tick  = 1'b0;
        if (!run) begin
            // Disabled block holds the divider at zero
            nx.cnt = '0;
        end else if (sel_now && !st.lvl) begin
            if (st.cnt == REF_DIV_LAST) begin
                nx.cnt  = '0;
                nx.tick = 1'b1;
            end else begin
                nx.cnt = st.cnt + 15'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign ref_level = st.lvl;
    assign sec_tick  = st.tick;

    // ********************************
    // Checks
    // ********************************
    chk_sec_period: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        st.tick |-> $past(st.cnt) == REF_DIV_LAST && st.cnt == 15'h0)
        else $error("second tick without full reference count");

endmodule : hcrtc_ref_div

/* include/hcrtc_pkg.sv */
// Constants and types shared by the hibernate calendar RTC core
package hcrtc_pkg;

    // ********************************
    // Register byte addresses
    // ********************************
    localparam logic [7:0] ADDR_CTL   = 8'h00; // Control
    localparam logic [7:0] ADDR_CNT   = 8'h04; // Seconds counter
    localparam logic [7:0] ADDR_CAL   = 8'h08; // Calendar time
    localparam logic [7:0] ADDR_MATCH = 8'h0c; // Match 0
    localparam logic [7:0] ADDR_STAT  = 8'h10; // Sticky status
    localparam logic [7:0] ADDR_MASK  = 8'h14; // Interrupt mask
    localparam logic [1:0] MEM_PAGE   = 2'h1;  // 0x40..0x7c retention

    // ********************************
    // Control field positions
    // ********************************
    localparam int CTL_EN     = 0;  // Block enable
    localparam int CTL_MODE   = 1;  // Mode, two bits
    localparam int CTL_OSC_PD = 3;  // Oscillator power down
    localparam int CTL_HI_DRV = 4;  // Crystal high drive
    localparam int CTL_LFI    = 5;  // Internal oscillator source
    localparam int CTL_CLKOUT = 6;  // Clock forwarding

    // ********************************
    // Status and mask field positions
    // ********************************
    localparam int ST_MATCH  = 0;   // Match 0 event
    localparam int ST_RD_INV = 1;   // Calendar read invalid

    // ********************************
    // Calendar field values
    // ********************************
    localparam logic [7:0] WILDCARD  = 8'hff; // Match any value
    localparam logic [7:0] MS_LAST   = 8'h3b; // 59
    localparam logic [7:0] HOUR_LAST = 8'h17; // 23
    localparam logic [7:0] DAY_FIRST = 8'h01;
    localparam logic [7:0] DAY_LAST  = 8'h1f; // 31
    localparam logic [7:0] HR_NOON   = 8'h0c; // 12
    localparam logic [7:0] HR_PM     = 8'h20; // PM flag in 12h form
    localparam logic [7:0] HR_MASK   = 8'h1f; // Hour bits in 12h form

    // ********************************
    // Reference timing
    // ********************************
    localparam int          REF_HZ       = 32768; // Crystal rate
    localparam logic [14:0] REF_DIV_LAST = 15'(REF_HZ - 1);

    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        rtc_seconds_mode  = 2'b00,
        calendar_24h_mode = 2'b01,
        calendar_12h_mode = 2'b10
    } hcrtc_mode_t;

    typedef struct packed {
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } hcrtc_cal_t;

    typedef struct packed {
        logic        clock_out_to_system;
        logic        select_low_freq_internal;
        logic        crystal_high_drive;
        logic        osc_power_down_option;
        hcrtc_mode_t mode;
        logic        en;
    } hcrtc_ctl_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } hcrtc_bus_t;

    // ********************************
    // Reset values
    // ********************************
    localparam hcrtc_cal_t CAL_RST = '{DAY_FIRST, 8'h00, 8'h00, 8'h00};
    localparam hcrtc_ctl_t CTL_RST = '{1'b0, 1'b0, 1'b0, 1'b0,
                                       rtc_seconds_mode, 1'b0};

endpackage : hcrtc_pkg

/* testbench/hcrtc_core_tb.sv */
// Self-checking testbench for the hibernate calendar RTC core
`timescale 1ns/100ps
module hcrtc_core_tb;
    import hcrtc_pkg::*;

    // ****************************************
    // Stimulus rows: write, read back, pins
    // ****************************************
    typedef struct packed {
        logic [7:0]  addr;     // Register address
        logic [31:0] wdata;    // Value written
        logic [31:0] exp_rd;   // Value read back
        logic [2:0]  exp_pin;  // Power down, high drive, low drive
        logic [2:0]  pin_mask; // Pins that matter in this row
    } hcrtc_row_t;

    // Last CTL row leaves the block disabled for the rows after it
    localparam hcrtc_row_t ROWS [8] = '{
        '{ADDR_CTL, 32'h11, 32'h11, 3'h2, 3'h7},  // High drive
        '{ADDR_CTL, 32'h07, 32'h01, 3'h1, 3'h7},  // Reserved mode, low drive
        '{ADDR_CTL, 32'h09, 32'h09, 3'h4, 3'h4},  // Oscillator powered down
        '{ADDR_CTL, 32'h10, 32'h10, 3'h4, 3'h7},  // Disabled wins
        '{8'h40, 32'ha5a5_0001, 32'ha5a5_0001, 3'h4, 3'h7}, // First word
        '{8'h7c, 32'h5a5a_fffe, 32'h5a5a_fffe, 3'h4, 3'h7}, // Last word
        '{8'h3c, 32'h1234_5678, 32'h0, 3'h4, 3'h7},  // Unmapped hole
        '{ADDR_MASK, 32'h3, 32'h3, 3'h4, 3'h7}
    };
    localparam int CYC_LIMIT = 80000; // One second tick dominates the run

    logic        clk_sys;
    logic        rst_n;
    hcrtc_bus_t  bus;
    logic [31:0] rdata;
    logic        osc_input_pin;
    logic        internal_low_freq_osc;
    logic        irq;
    logic        osc_power_down_option;
    logic        crystal_high_drive;
    logic        crystal_low_drive;
    logic        sys_clk_out;
    logic        run_ref;          // Toggle crystal pin every cycle
    logic [31:0] got;              // Last read value
    int          n_fail;
    int          samples_checked;
    int          cyc;              // Cycles since start
    int          n;                // Wait counter

    hcrtc_core i_hcrtc_core (
        .clk_sys               (clk_sys),
        .rst_n                 (rst_n),
        .bus                   (bus),
        .rdata                 (rdata),
        .osc_input_pin         (osc_input_pin),
        .internal_low_freq_osc (internal_low_freq_osc),
        .irq                   (irq),
        .osc_power_down_option (osc_power_down_option),
        .crystal_high_drive    (crystal_high_drive),
        .crystal_low_drive     (crystal_low_drive),
        .sys_clk_out           (sys_clk_out)
    );

    // ****************************************
    // Clock, reference and watchdog
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Fastest reference the synchroniser can follow: one edge per 2 cycles
    always @(posedge clk_sys) begin
        if (run_ref) begin
            osc_input_pin <= ~osc_input_pin;
        end
    end

    // Hang guard, counted as a mismatch
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe: take it mid-cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        @(negedge clk_sys);
        d = rdata;
    endtask : rd_reg

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t word got %h want %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t bit got %b want %b", $time, g, e);
        end
    endtask : chk_bit

    task automatic end_of_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        bus = '0;
        osc_input_pin = 1'b0;
        internal_low_freq_osc = 1'b0;
        run_ref = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        cyc = 0;
        // Outputs settle to their idle levels while reset is held
        @(negedge clk_sys);
        chk_bit(irq, 1'b0);
        chk_bit(osc_power_down_option, 1'b1);
        chk_word(rdata, 32'h0);
        @(posedge clk_sys);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_reg(ADDR_CAL, got);
        chk_word(got, 32'h0100_0000);
        // Table of plain register cases
        foreach (ROWS[i]) begin
            wr_reg(ROWS[i].addr, ROWS[i].wdata);
            rd_reg(ROWS[i].addr, got);
            chk_word(got, ROWS[i].exp_rd);
            repeat (2) @(negedge clk_sys);
            chk_word(32'({osc_power_down_option, crystal_high_drive,
                          crystal_low_drive} & ROWS[i].pin_mask),
                     32'(ROWS[i].exp_pin));
        end
        // Forwarded clock follows the chosen source
        @(posedge clk_sys);
        internal_low_freq_osc <= 1'b1;
        wr_reg(ADDR_CTL, 32'h61);
        repeat (8) @(negedge clk_sys);
        chk_bit(sys_clk_out, 1'b1);
        wr_reg(ADDR_CTL, 32'h41);
        repeat (8) @(negedge clk_sys);
        chk_bit(sys_clk_out, 1'b0);
        // Calendar mode first, then time 23:59:59 and a daily midnight match
        wr_reg(ADDR_CTL, 32'h03);
        wr_reg(ADDR_CAL, 32'h0117_3b3b);
        wr_reg(ADDR_MATCH, 32'hff00_0000);
        wr_reg(ADDR_MASK, 32'h1);
        rd_reg(ADDR_CAL, got);
        chk_word(got, 32'h0117_3b3b);
        rd_reg(ADDR_STAT, got);
        chk_word(got, 32'h2);
        chk_bit(irq, 1'b0);
        rd_reg(ADDR_STAT, got);
        chk_word(got, 32'h0);
        // One full second of reference edges, interrupt ends the wait
        @(posedge clk_sys);
        run_ref <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 70000) begin
            @(negedge clk_sys);
            n = n + 1;
        end
        chk_bit(n > 65500 && n < 65600, 1'b1);
        @(posedge clk_sys);
        run_ref <= 1'b0;
        rd_reg(ADDR_STAT, got);
        chk_word(got, 32'h1);
        rd_reg(ADDR_CAL, got);
        chk_word(got, 32'h0200_0000);
        chk_bit(irq, 1'b0);
        // Midnight shows as 12 AM; a 1 PM write reads back as 13 in 24h
        wr_reg(ADDR_CTL, 32'h05);
        rd_reg(ADDR_CAL, got);
        chk_word(got, 32'h020c_0000);
        wr_reg(ADDR_CAL, 32'h0221_0000);
        wr_reg(ADDR_CTL, 32'h03);
        rd_reg(ADDR_CAL, got);
        chk_word(got, 32'h020d_0000);
        // Reset in mid-run parks the oscillator and clears control
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(negedge clk_sys);
        chk_bit(osc_power_down_option, 1'b1);
        chk_bit(crystal_low_drive, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_reg(ADDR_CTL, got);
        chk_word(got, 32'h0);
        end_of_test();
    end

endmodule : hcrtc_core_tb
